// ### src/can_error_status_and_interrupts.sv
// Error counters, error flags and interrupt logic behind an APB slave
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "can_err_irq_map.svh"

module can_error_status_and_interrupts
  import can_err_irq_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic can_rx_pin,
  input wire logic tx_error,
  input wire logic tx_success,
  input wire logic rx_error,
  input wire logic rx_error_severe,
  input wire logic rx_success,
  input wire logic idle_11_seen,
  input wire logic rx_msg_valid,
  input wire logic rx_msg_buf,
  input wire logic [2:0] tx_buf_empty,
  input wire logic msg_error,
  output logic int_n,
  output logic sleep_mode,
  output logic listen_only,
  output logic bus_off
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_t s_r;
  state_t s_nxt;

  logic [5:0] idx;
  logic addr_ok;
  logic acc;
  logic wr_en;
  logic rd_setup;
  logic [7:0] pend;
  logic [2:0] code;
  logic [5:0] stat_cur;
  logic [7:0] err_state_cur;
  logic [7:0] status_cur;
  logic [7:0] hw_set;
  logic [7:0] hold;
  logic activity;
  logic ovf0_ev;
  logic ovf1_ev;
  logic rx0_ev;
  logic rx1_ev;
  logic err_ev;
  logic wake_ev;
  logic [8:0] tx_cnt_sum;
  logic [8:0] rx_cnt_sum;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign idx = paddr[7:2];
  assign addr_ok = (paddr[1:0] == 2'h0) &&
                   ((idx == `IDX_STATUS) || (idx == `IDX_MODE_CTRL) ||
                    (idx == `IDX_TX_CNT) || (idx == `IDX_RX_CNT) ||
                    (idx == `IDX_IRQ_EN) || (idx == `IDX_IRQ_FLAG) ||
                    (idx == `IDX_ERR_STATE));
  assign acc = psel & penable;
  // Zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = acc & ~addr_ok;
  assign wr_en = acc & pwrite & addr_ok & pstrb[0];
  assign rd_setup = psel & ~penable & ~pwrite;
  assign prdata = {24'h000000, s_r.rdata};

  // ----------------------------------------------------------------
  // Error state bits from the counters, the bus-off flag and the overflow flags
  // ----------------------------------------------------------------
  assign stat_cur[5] = s_r.bus_off;
  assign stat_cur[4] = (s_r.tx_cnt >= `LIM_PASSIVE);
  assign stat_cur[3] = (s_r.rx_cnt >= `LIM_PASSIVE);
  assign stat_cur[2] = (s_r.tx_cnt >= `LIM_WARN);
  assign stat_cur[1] = (s_r.rx_cnt >= `LIM_WARN);
  assign stat_cur[0] = stat_cur[2] | stat_cur[1];
  assign err_state_cur = {s_r.ovf1, s_r.ovf0, stat_cur};

  // ----------------------------------------------------------------
  // Interrupt code, enabled sources only
  // ----------------------------------------------------------------
  assign pend = s_r.irq_flag & s_r.irq_en;
  assign code = pend[`BIT_ERR] ? `ICODE_ERR :
                pend[`BIT_WAK] ? `ICODE_WAK :
                pend[`BIT_TX0] ? `ICODE_TX0 :
                pend[`BIT_TX1] ? `ICODE_TX1 :
                pend[`BIT_TX2] ? `ICODE_TX2 :
                pend[`BIT_RX0] ? `ICODE_RX0 :
                pend[`BIT_RX1] ? `ICODE_RX1 :
                `ICODE_NONE;
  assign status_cur = {s_r.mode, 1'b0, code, 1'b0};

  // ----------------------------------------------------------------
  // Hardware events
  // ----------------------------------------------------------------
  // Dominant edge on the synchronised bus pin counts as activity
  assign activity = s_r.rx_prev & ~s_r.sync_b;
  // A message for a buffer whose full flag is still set overflows
  assign ovf0_ev = rx_msg_valid & ~rx_msg_buf &
                   s_r.irq_flag[`BIT_RX0];
  assign ovf1_ev = rx_msg_valid & rx_msg_buf &
                   s_r.irq_flag[`BIT_RX1];
  assign rx0_ev = rx_msg_valid & ~rx_msg_buf &
                  ~s_r.irq_flag[`BIT_RX0];
  assign rx1_ev = rx_msg_valid & rx_msg_buf &
                  ~s_r.irq_flag[`BIT_RX1];
  assign err_ev = s_r.irq_en[`BIT_ERR] &
                  (ovf0_ev | ovf1_ev |
                   (stat_cur != s_r.err_state_prev));
  assign wake_ev = (s_r.mode == MODE_SLEEP) &
                   s_r.irq_en[`BIT_WAK] & activity;

  always_comb begin
    hw_set = 8'h00;
    hw_set[`BIT_RX0] = rx0_ev;
    hw_set[`BIT_RX1] = rx1_ev;
    hw_set[`BIT_TX0] = tx_buf_empty[0];
    hw_set[`BIT_TX1] = tx_buf_empty[1];
    hw_set[`BIT_TX2] = tx_buf_empty[2];
    hw_set[`BIT_ERR] = err_ev;
    hw_set[`BIT_WAK] = wake_ev;
    hw_set[`BIT_MERR] = msg_error;
  end

  // Flags whose cause is still standing refuse a clear
  always_comb begin
    hold = hw_set;
    hold[`BIT_ERR] = hw_set[`BIT_ERR] | s_r.ovf0 | s_r.ovf1;
  end

  // ----------------------------------------------------------------
  // Counter arithmetic, nine bits to catch the overflow
  // ----------------------------------------------------------------
  assign tx_cnt_sum = {1'b0, s_r.tx_cnt} + `TX_CNT_STEP;
  assign rx_cnt_sum = {1'b0, s_r.rx_cnt} +
                   (rx_error_severe ? `RX_CNT_STEP_SEVERE : 9'h001);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;

    // Bus pin synchroniser and edge history
    s_nxt.sync_a = can_rx_pin;
    s_nxt.sync_b = s_r.sync_a;
    s_nxt.rx_prev = s_r.sync_b;

    // Counters move only while the node takes part in the bus
    if (!s_r.bus_off) begin
      if (tx_error) begin
        if (tx_cnt_sum >= `LIM_BUS_OFF) begin
          s_nxt.tx_cnt = 8'hFF;
          s_nxt.bus_off = 1'b1;
          s_nxt.recov_cnt = 8'h00;
        end else begin
          s_nxt.tx_cnt = tx_cnt_sum[7:0];
        end
      end else if (tx_success && s_r.tx_cnt != 8'h00) begin
        s_nxt.tx_cnt = s_r.tx_cnt - 8'h01;
      end
      if (rx_error || rx_error_severe) begin
        if (rx_cnt_sum[8]) begin
          s_nxt.rx_cnt = 8'hFF;
        end else begin
          s_nxt.rx_cnt = rx_cnt_sum[7:0];
        end
      end else if (rx_success) begin
        if (s_r.rx_cnt >= `LIM_PASSIVE) begin
          s_nxt.rx_cnt = `RX_CNT_RESTORE;
        end else if (s_r.rx_cnt != 8'h00) begin
          s_nxt.rx_cnt = s_r.rx_cnt - 8'h01;
        end
      end
    end else if (idle_11_seen) begin
      // Recovery runs without software once enough idle is seen
      if (s_r.recov_cnt == `RECOVERY_COUNT - 8'h01) begin
        s_nxt.bus_off = 1'b0;
        s_nxt.tx_cnt = `RST_BYTE;
        s_nxt.rx_cnt = `RST_BYTE;
        s_nxt.recov_cnt = 8'h00;
      end else begin
        s_nxt.recov_cnt = s_r.recov_cnt + 8'h01;
      end
    end

    // Remember the error state so a change can raise the error flag
    s_nxt.err_state_prev = stat_cur;

    // Host access to the registers
    if (wr_en) begin
      unique case (idx)
        `IDX_IRQ_EN: begin
          s_nxt.irq_en = pwdata[7:0];
        end
        `IDX_IRQ_FLAG: begin
          // Ones set a flag, zeros clear it unless held
          s_nxt.irq_flag = pwdata[7:0] |
                           (s_r.irq_flag & hold);
        end
        `IDX_ERR_STATE: begin
          s_nxt.ovf1 = pwdata[7];
          s_nxt.ovf0 = pwdata[6];
        end
        `IDX_MODE_CTRL: begin
          unique case (pwdata[1:0])
            2'h0: s_nxt.mode = MODE_NORMAL;
            2'h1: s_nxt.mode = MODE_SLEEP;
            2'h2: s_nxt.mode = MODE_LISTEN;
            default: s_nxt.mode = s_r.mode;
          endcase
        end
        default: begin
          s_nxt.irq_en = s_r.irq_en;
        end
      endcase
    end

    // Hardware sets win over a host clear in the same cycle
    s_nxt.irq_flag = s_nxt.irq_flag | hw_set;
    s_nxt.ovf0 = s_nxt.ovf0 | ovf0_ev;
    s_nxt.ovf1 = s_nxt.ovf1 | ovf1_ev;

    // Wake-up leaves sleep into listen-only operation
    if (wake_ev) begin
      s_nxt.mode = MODE_LISTEN;
    end

    // Pin follows the next flag and enable values
    s_nxt.int_n = ~|(s_nxt.irq_flag & s_nxt.irq_en);

    // Read data captured in the setup cycle
    if (rd_setup) begin
      unique case (idx)
        `IDX_TX_CNT: s_nxt.rdata = s_r.tx_cnt;
        `IDX_RX_CNT: s_nxt.rdata = s_r.rx_cnt;
        `IDX_ERR_STATE: s_nxt.rdata = err_state_cur;
        `IDX_IRQ_EN: s_nxt.rdata = s_r.irq_en;
        `IDX_IRQ_FLAG: s_nxt.rdata = s_r.irq_flag;
        `IDX_STATUS: s_nxt.rdata = status_cur;
        `IDX_MODE_CTRL: s_nxt.rdata = {5'h00, s_r.mode};
        default: s_nxt.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r.tx_cnt <= `RST_BYTE;
      s_r.rx_cnt <= `RST_BYTE;
      s_r.bus_off <= 1'b0;
      s_r.recov_cnt <= 8'h00;
      s_r.ovf0 <= 1'b0;
      s_r.ovf1 <= 1'b0;
      s_r.irq_en <= `RST_BYTE;
      s_r.irq_flag <= `RST_BYTE;
      s_r.mode <= MODE_NORMAL;
      s_r.err_state_prev <= 6'h00;
      s_r.int_n <= 1'b1;
      s_r.rdata <= 8'h00;
      s_r.sync_a <= 1'b1;
      s_r.sync_b <= 1'b1;
      s_r.rx_prev <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign int_n = s_r.int_n;
  assign sleep_mode = (s_r.mode == MODE_SLEEP);
  assign listen_only = (s_r.mode == MODE_LISTEN);
  assign bus_off = s_r.bus_off;

endmodule

// ### pkg/can_err_irq_map.svh
// Register indices, field positions, reset values and limits
`ifndef CAN_ERR_IRQ_MAP_SVH
`define CAN_ERR_IRQ_MAP_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_STATUS 6'h0E
`define IDX_MODE_CTRL 6'h0F
`define IDX_TX_CNT 6'h1C
`define IDX_RX_CNT 6'h1D
`define IDX_IRQ_EN 6'h2B
`define IDX_IRQ_FLAG 6'h2C
`define IDX_ERR_STATE 6'h2D

// ----------------------------------------------------------------
// Interrupt source bit positions (enable and flag alike)
// ----------------------------------------------------------------
`define BIT_RX0 0
`define BIT_RX1 1
`define BIT_TX0 2
`define BIT_TX1 3
`define BIT_TX2 4
`define BIT_ERR 5
`define BIT_WAK 6
`define BIT_MERR 7

// ----------------------------------------------------------------
// Interrupt codes, lower value wins
// ----------------------------------------------------------------
`define ICODE_NONE 3'h0
`define ICODE_ERR 3'h1
`define ICODE_WAK 3'h2
`define ICODE_TX0 3'h3
`define ICODE_TX1 3'h4
`define ICODE_TX2 3'h5
`define ICODE_RX0 3'h6
`define ICODE_RX1 3'h7

// ----------------------------------------------------------------
// Reset values, limits and counts
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define LIM_WARN 8'h60
`define LIM_PASSIVE 8'h80
`define LIM_BUS_OFF 9'h0FF
`define TX_CNT_STEP 9'h008
`define RX_CNT_STEP_SEVERE 9'h008
`define RX_CNT_RESTORE 8'h77
`define RECOVERY_COUNT 8'h80

`endif

// ### pkg/can_err_irq_pkg.sv
// Types shared by the error status and interrupt block
package can_err_irq_pkg;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_LISTEN = 3'b100
  } mode_t;

  typedef struct packed {
    logic [7:0] tx_cnt;
    logic [7:0] rx_cnt;
    logic bus_off;
    logic [7:0] recov_cnt;
    logic ovf0;
    logic ovf1;
    logic [7:0] irq_en;
    logic [7:0] irq_flag;
    mode_t mode;
    logic [5:0] err_state_prev;
    logic int_n;
    logic [7:0] rdata;
    logic sync_a;
    logic sync_b;
    logic rx_prev;
  } state_t;

endpackage

// ### sim/can_err_irq_sva.sv
// Port-level checks for the error status and interrupt block
`timescale 1ns/1ps
module can_err_irq_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic can_rx_pin,
  input wire logic tx_error,
  input wire logic idle_11_seen,
  input wire logic int_n,
  input wire logic sleep_mode,
  input wire logic listen_only,
  input wire logic bus_off
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic wr_acc;
  assign wr_acc = psel && penable && pwrite;
  sequence rise_s;
    !bus_off ##1 bus_off;
  endsequence
  sequence fall_s;
    bus_off ##1 !bus_off;
  endsequence
  // Pin held recessive long enough that no falling edge can be in flight
  sequence quiet_s;
    (sleep_mode && can_rx_pin && !psel) [*4];
  endsequence
  ready_now_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  upper_zero_a: assert property (
    psel && penable && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  off_cause_a: assert property (rise_s |-> $past(tx_error))
    else $error("bus off without transmit error");
  off_hold_a: assert property (
    bus_off && !idle_11_seen |=> bus_off)
    else $error("bus off left without recovery");
  recover_cause_a: assert property (fall_s |-> $past(idle_11_seen))
    else $error("bus off cleared without idle sequence");
  int_release_a: assert property ($rose(int_n) |-> $past(wr_acc))
    else $error("interrupt released without host write");
  sleep_hold_a: assert property (quiet_s |=> sleep_mode)
    else $error("left sleep without bus activity");
  mode_excl_a: assert property (!(sleep_mode && listen_only))
    else $error("sleep and listen at once");
  wake_listen_a: assert property (
    $fell(sleep_mode) && !$past(wr_acc) |-> listen_only)
    else $error("wake did not enter listen only");
endmodule

bind can_error_status_and_interrupts can_err_irq_sva i_sva (.pclk,
  .presetn, .psel, .penable, .pwrite, .prdata, .pready, .can_rx_pin,
  .tx_error, .idle_11_seen, .int_n, .sleep_mode, .listen_only, .bus_off);

// ### sim/can_engine_model.sv
// Protocol engine and bus pin model that feeds events to the block
`timescale 1ns/1ps
module can_engine_model (
  input wire logic pclk,
  output logic can_rx_pin,
  output logic tx_error,
  output logic tx_success,
  output logic rx_error,
  output logic rx_error_severe,
  output logic rx_success,
  output logic idle_11_seen,
  output logic rx_msg_valid,
  output logic rx_msg_buf,
  output logic [2:0] tx_buf_empty,
  output logic msg_error
);
  logic [11:0] ev_r;
  assign {msg_error, tx_buf_empty, rx_msg_buf, rx_msg_valid, idle_11_seen,
    rx_success, rx_error_severe, rx_error, tx_success, tx_error} = ev_r;
  initial begin
    ev_r = 12'h000;
    can_rx_pin = 1'b1;
  end
  // One-cycle events with a quiet cycle between, as frames never overlap
  task automatic fire(input logic [11:0] v, input int n);
    repeat (n) begin
      @(posedge pclk);
      ev_r <= v;
      @(posedge pclk);
      ev_r <= 12'h000;
    end
  endtask
  // Dominant edge after an idle spell, then recessive again
  task automatic wake();
    repeat (6) @(posedge pclk);
    can_rx_pin <= 1'b0;
    repeat (3) @(posedge pclk);
    can_rx_pin <= 1'b1;
  endtask
endmodule

// ### sim/can_error_status_and_interrupts_tb.sv
// Self-checking bench for the error status and interrupt block
`timescale 1ns/1ps
`include "can_err_irq_map.svh"
module can_error_status_and_interrupts_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, fl;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic can_rx_pin, tx_error, tx_success, rx_error, rx_error_severe;
  logic rx_success, idle_11_seen, rx_msg_valid, rx_msg_buf, msg_error;
  logic int_n, sleep_mode, listen_only, bus_off;
  logic [2:0] tx_buf_empty;
  int failures, cmp_count, i;
  int prio [7] = '{5, 6, 2, 3, 4, 0, 1};
  localparam logic [7:0] a_txc = {`IDX_TX_CNT, 2'b00};
  localparam logic [7:0] a_rxc = {`IDX_RX_CNT, 2'b00};
  localparam logic [7:0] a_efl = {`IDX_ERR_STATE, 2'b00};
  localparam logic [7:0] a_en = {`IDX_IRQ_EN, 2'b00};
  localparam logic [7:0] a_fl = {`IDX_IRQ_FLAG, 2'b00};
  localparam logic [7:0] a_st = {`IDX_STATUS, 2'b00};
  localparam logic [7:0] a_md = {`IDX_MODE_CTRL, 2'b00};
  can_error_status_and_interrupts i_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .can_rx_pin, .tx_error, .tx_success, .rx_error, .rx_error_severe,
    .rx_success, .idle_11_seen, .rx_msg_valid, .rx_msg_buf, .tx_buf_empty,
    .msg_error, .int_n, .sleep_mode, .listen_only, .bus_off);
  can_engine_model i_eng (.pclk, .can_rx_pin, .tx_error, .tx_success,
    .rx_error, .rx_error_severe, .rx_success, .idle_11_seen, .rx_msg_valid,
    .rx_msg_buf, .tx_buf_empty, .msg_error);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ------------------------------------------------------------
  // Bus access and comparison
  // ------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [7:0] e,
    input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rchk(input string n, input logic [7:0] a,
    input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(n, e, rd[7:0]);
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    test_done;
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    failures = 0;
    cmp_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk("txcnt", a_txc, 8'h00);
    rchk("rxcnt", a_rxc, 8'h00);
    rchk("errflags", a_efl, 8'h00);
    xfer(1'b1, a_txc, 8'hFF);
    rchk("txcnt ro", a_txc, 8'h00);
    xfer(1'b0, 8'hFC, 8'h00);
    chk("unmapped", 8'h01, {7'h0, er});
    xfer(1'b1, a_en, 8'h20);
    i_eng.fire(12'h001, 12);
    rchk("warn", a_efl, 8'h05);
    i_eng.fire(12'h002, 1);
    rchk("warn off", a_efl, 8'h00);
    i_eng.fire(12'h001, 5);
    rchk("tx passive", a_efl, 8'h15);
    i_eng.fire(12'h008, 16);
    rchk("rx passive", a_efl, 8'h1F);
    i_eng.fire(12'h010, 1);
    rchk("rx restore", a_rxc, 8'h77);
    i_eng.fire(12'h004, 1);
    rchk("rx inc", a_rxc, 8'h78);
    rchk("rx active", a_efl, 8'h17);
    i_eng.fire(12'h001, 16);
    rchk("txcnt sat", a_txc, 8'hFF);
    rchk("bus off", a_efl, 8'h37);
    rchk("err flag", a_fl, 8'h20);
    chk("int low", 8'h00, {7'h0, int_n});
    i_eng.fire(12'h020, 127);
    chk("still off", 8'h01, {7'h0, bus_off});
    i_eng.fire(12'h020, 1);
    rchk("recovered", a_efl, 8'h00);
    rchk("txcnt clr", a_txc, 8'h00);
    xfer(1'b1, a_fl, 8'h00);
    @(negedge pclk);
    chk("int off", 8'h01, {7'h0, int_n});
    xfer(1'b1, a_en, 8'hFF);
    fl = 8'h7F;
    xfer(1'b1, a_fl, fl);
    @(negedge pclk);
    chk("host int", 8'h00, {7'h0, int_n});
    for (i = 0; i < 7; i++) begin
      rchk("code", a_st, {3'b001, 1'b0, 3'(i + 1), 1'b0});
      fl[prio[i]] = 1'b0;
      xfer(1'b1, a_fl, fl);
    end
    rchk("code none", a_st, 8'h20);
    xfer(1'b1, a_en, 8'h01);
    xfer(1'b1, a_fl, 8'h21);
    rchk("masked code", a_st, 8'h2C);
    xfer(1'b1, a_en, 8'h20);
    xfer(1'b1, a_fl, 8'h00);
    for (i = 0; i < 4; i++) begin
      i_eng.fire(i < 2 ? 12'h040 : 12'h0C0, 1);
    end
    rchk("overflow", a_efl, 8'hC0);
    rchk("rx full", a_fl, 8'h23);
    xfer(1'b1, a_fl, 8'h00);
    rchk("err kept", a_fl, 8'h20);
    xfer(1'b1, a_efl, 8'h00);
    xfer(1'b1, a_fl, 8'h00);
    rchk("err clr", a_fl, 8'h00);
    xfer(1'b1, a_en, 8'h00);
    i_eng.fire(12'h700, 1);
    i_eng.fire(12'h800, 1);
    rchk("tx msg", a_fl, 8'h9C);
    chk("no int", 8'h01, {7'h0, int_n});
    xfer(1'b1, a_en, 8'h80);
    @(negedge pclk);
    chk("msg int", 8'h00, {7'h0, int_n});
    xfer(1'b1, a_en, 8'h00);
    @(negedge pclk);
    chk("masked off", 8'h01, {7'h0, int_n});
    xfer(1'b1, a_fl, 8'h00);
    xfer(1'b1, a_en, 8'h40);
    xfer(1'b1, a_md, 8'h01);
    i_eng.wake();
    i = 0;
    while (listen_only !== 1'b1 && i < 10) begin
      @(posedge pclk);
      i++;
    end
    @(negedge pclk);
    chk("listen", 8'h01, {7'h0, listen_only});
    chk("wake int", 8'h00, {7'h0, int_n});
    rchk("wake flag", a_fl, 8'h40);
    rchk("mode listen", a_md, 8'h04);
    xfer(1'b1, a_md, 8'h03);
    rchk("mode keep", a_md, 8'h04);
    xfer(1'b1, a_md, 8'h00);
    rchk("mode normal", a_md, 8'h01);
    test_done;
  end
endmodule
